// ---- interleave_pkg.sv ----
package interleave_pkg;

   // ----------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------
   localparam int RESULT_W   = 12;
   localparam int POS_W      = 4;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------------------------------
   // Common timer: one period is one per-core sample period
   // ----------------------------------------------------------------
   localparam int          TIMER_PERIOD  = 2;
   localparam logic [0:0]  TIMER_COMPARE = 1'h0;
   localparam logic [0:0]  TIMER_TOP     = 1'h1;
   localparam logic [0:0]  TIMER_STEP    = 1'h1;

   // ----------------------------------------------------------------
   // Reset values and buffer position step
   // ----------------------------------------------------------------
   localparam logic [POS_W-1:0]    POS_RESET    = 4'h0;
   localparam logic [POS_W-1:0]    POS_STEP     = 4'h1;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                valid;
      logic [RESULT_W-1:0] data;
   } result_type;

   typedef struct packed {
      logic                unit;
      logic [POS_W-1:0]    pos;
      logic [RESULT_W-1:0] data;
   } sample_type;

   localparam int SAMPLE_W = $bits(sample_type);

endpackage

// ---- sample_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } fifo_state_type;

   fifo_state_type   st_reg;
   fifo_state_type   st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign empty     = st_reg.wr_ptr == st_reg.rd_ptr;
   assign full      = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) &&
                      (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[st_reg.rd_ptr[AW-1:0]];
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr_ptr = st_reg.wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
      if (push) begin
         mem[st_reg.wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule

`default_nettype wire

// ---- interleaved_adc_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none

module interleaved_adc_sequencer (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           run,
   output logic                                odd_sample_clk,
   output logic                                even_sample_clk,
   output logic                                first_start,
   output logic                                second_start,
   input  wire interleave_pkg::result_type     first_result,
   output logic                                first_ready,
   input  wire interleave_pkg::result_type     second_result,
   output logic                                second_ready,
   output logic                                stream_valid,
   input  wire logic                           stream_ready,
   output interleave_pkg::sample_type          stream_sample,
   output logic                                overrun
);

   import interleave_pkg::*;

   typedef struct packed {
      logic                run;
      logic [0:0]          timer;
      logic                odd_clk;
      logic                even_clk;
      logic                first_trig;
      logic                second_trig;
      logic                ch0_pend;
      logic [RESULT_W-1:0] ch0_data;
      logic                ch1_pend;
      logic [RESULT_W-1:0] ch1_data;
      logic                want_second;
      logic [POS_W-1:0]    pos;
      logic                out_valid;
      sample_type          out_word;
      logic                overrun;
   } seq_state_type;

   seq_state_type st_reg;
   seq_state_type st_next;
   sample_type    push_word;
   sample_type    fifo_word;
   logic          push;
   logic          push_valid;
   logic          fifo_ready;
   logic          fifo_valid;
   logic          fifo_take;
   logic          compare_hit;
   logic          overflow_hit;

   // ----------------------------------------------------------------
   // Shared buffer path
   // ----------------------------------------------------------------
   assign push_valid = st_reg.want_second ? st_reg.ch1_pend
                                          : st_reg.ch0_pend;
   assign push       = push_valid && fifo_ready;
   assign fifo_take  = fifo_valid && (!st_reg.out_valid || stream_ready);

   always_comb begin
      push_word.unit = st_reg.want_second;
      push_word.pos  = st_reg.pos;
      push_word.data = st_reg.want_second ? st_reg.ch1_data
                                          : st_reg.ch0_data;
   end

   sample_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push_valid),
      .in_ready  (fifo_ready),
      .in_data   (push_word),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_word)
   );

   // ----------------------------------------------------------------
   // Timer, clocks and merge
   // ----------------------------------------------------------------
   assign compare_hit  = st_reg.run && (st_reg.timer == TIMER_COMPARE);
   assign overflow_hit = st_reg.run && (st_reg.timer == TIMER_TOP);

   always_comb begin
      st_next     = st_reg;
      st_next.run = run;
      // Idle timer parks on compare so the odd core always leads
      if (!st_reg.run) begin
         st_next.timer = TIMER_COMPARE;
      end else if (st_reg.timer == TIMER_TOP) begin
         st_next.timer = TIMER_COMPARE;
      end else begin
         st_next.timer = st_reg.timer + TIMER_STEP;
      end
      st_next.odd_clk     = compare_hit;
      st_next.even_clk    = st_reg.run && !compare_hit;
      st_next.first_trig  = compare_hit;
      st_next.second_trig = overflow_hit;

      // Dedicated channel per unit
      if (push && !st_reg.want_second) begin
         st_next.ch0_pend = 1'b0;
      end
      if (push && st_reg.want_second) begin
         st_next.ch1_pend = 1'b0;
      end
      if (first_result.valid && !st_reg.ch0_pend) begin
         st_next.ch0_pend = 1'b1;
         st_next.ch0_data = first_result.data;
      end
      if (second_result.valid && !st_reg.ch1_pend) begin
         st_next.ch1_pend = 1'b1;
         st_next.ch1_data = second_result.data;
      end
      if ((first_result.valid && st_reg.ch0_pend) ||
          (second_result.valid && st_reg.ch1_pend)) begin
         st_next.overrun = 1'b1;
      end

      // Alternate units into consecutive buffer positions
      if (push) begin
         st_next.want_second = !st_reg.want_second;
         st_next.pos         = st_reg.pos + POS_STEP;
      end

      // Output register
      if (fifo_take) begin
         st_next.out_valid = 1'b1;
         st_next.out_word  = fifo_word;
      end else if (stream_ready) begin
         st_next.out_valid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg               <= '0;
         st_reg.timer         <= TIMER_COMPARE;
         st_reg.pos           <= POS_RESET;
         st_reg.ch0_data      <= RESULT_RESET;
         st_reg.ch1_data      <= RESULT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign odd_sample_clk  = st_reg.odd_clk;
   assign even_sample_clk = st_reg.even_clk;
   assign first_start     = st_reg.first_trig;
   assign second_start    = st_reg.second_trig;
   assign first_ready     = !st_reg.ch0_pend;
   assign second_ready    = !st_reg.ch1_pend;
   assign stream_valid    = st_reg.out_valid;
   assign stream_sample   = st_reg.out_word;
   assign overrun         = st_reg.overrun;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_DIVIDE: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.odd_clk && st_reg.run && $past(st_reg.run) |=> !st_reg.odd_clk)
      else $error("Divided clock high for more than one cycle");

   AST_LOW_TIME: assert property (
      @(posedge clk) disable iff (rst)
      !st_reg.odd_clk && st_reg.run && $past(st_reg.run) |=> st_reg.odd_clk)
      else $error("Divided clock low for more than one cycle");

   AST_ANTIPHASE: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.odd_clk |-> !st_reg.even_clk)
      else $error("Divided clocks not in antiphase");

   AST_INVERSE: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.run && $past(st_reg.run) |-> st_reg.even_clk != st_reg.odd_clk)
      else $error("Second divided clock not the inverse of first");

   AST_RISE_START: assert property (
      @(posedge clk) disable iff (rst)
      $rose(st_reg.odd_clk) |-> st_reg.first_trig)
      else $error("First unit not started on its rising edge");

   AST_HALF_PERIOD: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.first_trig && st_reg.run |=> st_reg.second_trig)
      else $error("Second start not half a period after first");

   AST_ALTERNATE: assert property (
      @(posedge clk) disable iff (rst)
      push |=> st_reg.want_second != $past(st_reg.want_second))
      else $error("Units did not alternate");

   AST_EVEN_POS: assert property (
      @(posedge clk) disable iff (rst)
      push && !st_reg.want_second |-> push_word.pos[0] == 1'b0)
      else $error("First unit result at odd position");

   AST_POS_STEP: assert property (
      @(posedge clk) disable iff (rst)
      push |=> st_reg.pos == $past(st_reg.pos) + POS_STEP)
      else $error("Buffer position did not advance by one");

   AST_CHANNEL_HOLD: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.ch0_pend && !(push && !st_reg.want_second)
      |=> st_reg.ch0_pend && $stable(st_reg.ch0_data))
      else $error("First channel request lost");

   AST_STREAM_HOLD: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.out_valid && !stream_ready
      |=> st_reg.out_valid && $stable(st_reg.out_word))
      else $error("Stream sample dropped under back-pressure");

endmodule

`default_nettype wire

// ---- converter_pair_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module converter_pair_model #(
   parameter int LATENCY = 3
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  first_start,
   input  wire logic                  second_start,
   output interleave_pkg::result_type first_result,
   output interleave_pkg::result_type second_result
);
   import interleave_pkg::*;

   // ----------------------------------------------------------------
   // Two cores on one ramp input
   // ----------------------------------------------------------------
   logic [LATENCY-1:0]  first_pipe_reg;
   logic [LATENCY-1:0]  second_pipe_reg;
   logic [RESULT_W-2:0] count_reg;
   logic [RESULT_W-1:0] idle_reg;

   // Conversion time after each start
   always @(posedge clk) begin
      if (rst) begin
         first_pipe_reg  <= '0;
         second_pipe_reg <= '0;
         count_reg       <= '0;
         idle_reg        <= 12'h555;
      end else begin
         first_pipe_reg  <= {first_pipe_reg[LATENCY-2:0], first_start};
         second_pipe_reg <= {second_pipe_reg[LATENCY-2:0], second_start};
         if (second_pipe_reg[LATENCY-1]) begin
            count_reg <= count_reg + 1'b1;
         end
         idle_reg <= ~idle_reg;
      end
   end

   // Data lines toggle when no result is offered
   always_comb begin
      first_result.valid  = first_pipe_reg[LATENCY-1];
      first_result.data   = first_pipe_reg[LATENCY-1] ? {count_reg, 1'b0}
                                                      : idle_reg;
      second_result.valid = second_pipe_reg[LATENCY-1];
      second_result.data  = second_pipe_reg[LATENCY-1] ? {count_reg, 1'b1}
                                                       : ~idle_reg;
   end
endmodule

`default_nettype wire

// ---- interleaved_adc_sequencer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module interleaved_adc_sequencer_tb;
   import interleave_pkg::*;

   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       run = 1'b0;
   logic       stream_ready = 1'b1;
   logic       watch = 1'b1;
   logic       odd_sample_clk, even_sample_clk, first_start, second_start;
   logic       first_ready, second_ready, stream_valid, overrun;
   result_type first_result, second_result;
   sample_type stream_sample;
   int         mismatches = 0;
   int         check_count = 0;
   int         cycles = 0;
   int         k = 0;

   always #5 clk = ~clk;

   interleaved_adc_sequencer DUT (
      .clk(clk), .rst(rst), .run(run),
      .odd_sample_clk(odd_sample_clk), .even_sample_clk(even_sample_clk),
      .first_start(first_start), .second_start(second_start),
      .first_result(first_result), .first_ready(first_ready),
      .second_result(second_result), .second_ready(second_ready),
      .stream_valid(stream_valid), .stream_ready(stream_ready),
      .stream_sample(stream_sample), .overrun(overrun));

   converter_pair_model cores (
      .clk(clk), .rst(rst), .first_start(first_start),
      .second_start(second_start), .first_result(first_result),
      .second_result(second_result));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   task results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         results;
      end
   end

   // While watch is set, every accepted sample follows the ramp
   always @(posedge clk) begin
      if (watch && stream_valid === 1'b1 && stream_ready) begin
         check(stream_sample.unit, k[0], "unit");
         check(stream_sample.pos, k[3:0], "pos");
         check(stream_sample.data, k[11:0], "data");
         k++;
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task test_clocks;
      int n;
      n = 0;
      run = 1'b1;
      while (first_start !== 1'b1 && n < 10) begin
         @(negedge clk);
         check(second_start, 1'b0, "second before first");
         n++;
      end
      check(n, 2, "start latency");
      for (int i = 0; i < 8; i++) begin
         check(odd_sample_clk, !i[0], "odd clock");
         check(even_sample_clk, i[0], "even clock");
         check(first_start, !i[0], "first start");
         check(second_start, i[0], "second start");
         @(negedge clk);
      end
      $display("test clocks done");
   endtask

   task test_rate;
      int start;
      repeat (10) @(negedge clk);
      start = k;
      repeat (32) @(negedge clk);
      check(k - start, 32, "merged rate");
      check(k > 20, 1'b1, "pos wrapped");
      check(overrun, 1'b0, "no overrun");
      $display("test rate done");
   endtask

   task test_stall;
      int n;
      n = 0;
      watch = 1'b0;
      stream_ready = 1'b0;
      repeat (30) @(negedge clk);
      check(stream_valid, 1'b1, "valid held");
      check(first_ready & second_ready, 1'b0, "busy");
      check(overrun, 1'b1, "overrun");
      run = 1'b0;
      stream_ready = 1'b1;
      repeat (3) @(negedge clk);
      check({odd_sample_clk, even_sample_clk, first_start, second_start},
            4'h0, "idle clocks");
      while (stream_valid === 1'b1 && n < 30) begin
         @(negedge clk);
         n++;
      end
      check(n >= 6 && n < 30, 1'b1, "drain count");
      check(first_ready & second_ready, 1'b1, "free");
      check(overrun, 1'b1, "overrun sticky");
      $display("test stall done");
   endtask

   task test_reset;
      run = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check({odd_sample_clk, even_sample_clk, first_start, second_start,
             stream_valid, overrun}, 6'h00, "reset clears");
      check(first_ready & second_ready, 1'b1, "reset frees");
      rst = 1'b0;
      repeat (2) @(negedge clk);
      check({odd_sample_clk, first_start, even_sample_clk}, 3'h6,
            "restart odd first");
      $display("test reset done");
   endtask

   initial begin
      repeat (5) @(negedge clk);
      check(odd_sample_clk | even_sample_clk | first_start | second_start |
            stream_valid | overrun, 1'b0, "reset outputs");
      check(first_ready & second_ready, 1'b1, "reset ready");
      rst = 1'b0;
      test_clocks;
      test_rate;
      test_stall;
      test_reset;
      results;
   end
endmodule

`default_nettype wire
